// *** verilog/llu_pkg.sv ***
package llu_pkg;
  localparam int XLEN = 64;
  localparam int IW = 32;
  localparam logic [5:0] OP_LOAD_LINKED_WORD = 6'h30;
  localparam logic [5:0] OP_LOAD_LINKED_DOUBLE = 6'h34;
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int BASE_HI = 25;
  localparam int BASE_LO = 21;
  localparam int TGT_HI = 20;
  localparam int TGT_LO = 16;
  localparam int OFS_HI = 15;
  localparam int OFS_LO = 0;
  localparam logic [1:0] WORD_ALIGN_MASK = 2'h3;
  localparam logic [2:0] DBL_ALIGN_MASK = 3'h7;
  localparam int LANE_BIT = 2;
  localparam int WORD_W = 32;
  localparam int STAT_W = 4;
  localparam int EV_LOAD_DONE = 0;
  localparam int EV_ADDR_ERR = 1;
  localparam int EV_XLAT_ERR = 2;
  localparam int EV_RSVD = 3;

  typedef enum logic [2:0] {
    LLU_EXC_NONE,
    LLU_EXC_ADDR_ERROR,
    LLU_EXC_XLAT_REFILL,
    LLU_EXC_XLAT_INVALID,
    LLU_EXC_RESERVED_INSTR
  } llu_exc_e;

  typedef struct packed {
    logic valid;
    logic [IW-1:0] instr;
    logic [XLEN-1:0] base_val;
  } llu_issue_s;

  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] addr;
    logic is_double;
    logic shared_only;
  } llu_mem_req_s;

  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] data;
    logic xlat_refill;
    logic xlat_invalid;
  } llu_mem_rsp_s;

  typedef struct packed {
    logic valid;
    logic [4:0] target_reg_field;
    logic [XLEN-1:0] data;
  } llu_wb_s;
endpackage

// *** verilog/llu_decode.sv ***
`timescale 1ns/100ps
module llu_decode
  import llu_pkg::*;
(
  // Instruction and operand
  input wire logic [IW-1:0] instr,
  input wire logic [XLEN-1:0] base_val,
  input wire logic ll_enable,
  // Decode results
  output logic is_word,
  output logic is_double,
  output logic reserved,
  output logic [4:0] base_field,
  output logic [4:0] tgt_field,
  output logic [XLEN-1:0] eff_addr,
  output logic misaligned
);
  logic [5:0] opc;

  always_comb begin
    opc = instr[OPC_HI:OPC_LO];
    is_word = (opc == OP_LOAD_LINKED_WORD);
    is_double = (opc == OP_LOAD_LINKED_DOUBLE);
    reserved = (is_word | is_double) & ~ll_enable;
    base_field = instr[BASE_HI:BASE_LO];
    tgt_field = instr[TGT_HI:TGT_LO];
    eff_addr = base_val + {{(XLEN-16){instr[OFS_HI]}}, instr[OFS_HI:OFS_LO]};
    misaligned = is_double ? |(eff_addr[2:0] & DBL_ALIGN_MASK)
                           : |(eff_addr[1:0] & WORD_ALIGN_MASK);
  end
endmodule

// *** verilog/load_linked_unit.sv ***
`timescale 1ns/100ps
module load_linked_unit
  import llu_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Issue from the pipeline
  input wire llu_pkg::llu_issue_s issue,
  input wire logic ll_enable,
  input wire logic cpu_big_endian_mode,
  output logic busy_r,
  // Store-conditional end of sequence
  input wire logic sc_done,
  // Cache and memory side
  output llu_pkg::llu_mem_req_s mem_req_r,
  input wire llu_pkg::llu_mem_rsp_s mem_rsp,
  // Register writeback and exceptions
  output llu_pkg::llu_wb_s wb_r,
  output llu_pkg::llu_exc_e exc_r,
  output logic link_flag_r,
  output logic [XLEN-1:0] link_addr_r,
  // Status and interrupt
  input wire logic [STAT_W-1:0] stat_clr,
  input wire logic [STAT_W-1:0] mask_wr_data,
  input wire logic mask_wr,
  output logic [STAT_W-1:0] status_r,
  output logic irq_r
);
  typedef enum logic [1:0] {LLU_IDLE, LLU_WAIT} llu_state_e;

  llu_state_e state_r;
  logic dec_word, dec_double, dec_rsvd, dec_mis;
  logic [4:0] dec_base, dec_tgt;
  logic [XLEN-1:0] dec_addr;
  logic pend_double_r;
  logic [4:0] pend_tgt_r;
  logic [2:0] pend_lane_r;
  logic [STAT_W-1:0] mask_r;
  logic [STAT_W-1:0] events;
  logic accept, load_ok;
  logic [WORD_W-1:0] word_sel;

  llu_decode u_dec (
    .instr(issue.instr),
    .base_val(issue.base_val),
    .ll_enable(ll_enable),
    .is_word(dec_word),
    .is_double(dec_double),
    .reserved(dec_rsvd),
    .base_field(dec_base),
    .tgt_field(dec_tgt),
    .eff_addr(dec_addr),
    .misaligned(dec_mis)
  );

  // Only decodable, aligned, permitted requests reach the cache
  assign accept = issue.valid && (state_r == LLU_IDLE) && (dec_word | dec_double) && !dec_rsvd && !dec_mis;
  assign load_ok = (state_r == LLU_WAIT) && mem_rsp.valid && !mem_rsp.xlat_refill && !mem_rsp.xlat_invalid;
  // Lane index already folds in the endian mode, captured at issue time
  assign word_sel = mem_rsp.data[pend_lane_r[LANE_BIT]*WORD_W +: WORD_W];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= LLU_IDLE;
      busy_r <= 1'b0;
    end else begin
      unique case (state_r)
        LLU_IDLE: begin
          if (accept) begin
            state_r <= LLU_WAIT;
            busy_r <= 1'b1;
          end
        end
        LLU_WAIT: begin
          if (mem_rsp.valid) begin
            state_r <= LLU_IDLE;
            busy_r <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pend_double_r <= 1'b0;
      pend_tgt_r <= 5'h00;
      pend_lane_r <= 3'h0;
    end else if (accept) begin
      pend_double_r <= dec_double;
      pend_tgt_r <= dec_tgt;
      pend_lane_r <= dec_addr[2:0] ^ {cpu_big_endian_mode, 2'h0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mem_req_r <= '0;
    end else begin
      mem_req_r.valid <= accept;
      if (accept) begin
        mem_req_r.addr <= dec_addr;
        mem_req_r.is_double <= dec_double;
        // Shared fetch keeps other caches' copies, so their pending sequences survive
        mem_req_r.shared_only <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wb_r <= '0;
    end else begin
      wb_r.valid <= load_ok;
      if (load_ok) begin
        wb_r.target_reg_field <= pend_tgt_r;
        if (pend_double_r) begin
          wb_r.data <= mem_rsp.data;
        end else begin
          wb_r.data <= {{(XLEN-WORD_W){word_sel[WORD_W-1]}}, word_sel};
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      exc_r <= LLU_EXC_NONE;
    end else if (issue.valid && state_r == LLU_IDLE && dec_rsvd) begin
      exc_r <= LLU_EXC_RESERVED_INSTR;
    end else if (issue.valid && state_r == LLU_IDLE && (dec_word | dec_double) && dec_mis) begin
      exc_r <= LLU_EXC_ADDR_ERROR;
    end else if (state_r == LLU_WAIT && mem_rsp.valid && mem_rsp.xlat_refill) begin
      exc_r <= LLU_EXC_XLAT_REFILL;
    end else if (state_r == LLU_WAIT && mem_rsp.valid && mem_rsp.xlat_invalid) begin
      exc_r <= LLU_EXC_XLAT_INVALID;
    end else begin
      exc_r <= LLU_EXC_NONE;
    end
  end

  // Link flag stays up with no store-conditional; a new load wins over a same-cycle end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      link_flag_r <= 1'b0;
      link_addr_r <= '0;
    end else if (load_ok) begin
      link_flag_r <= 1'b1;
      link_addr_r <= mem_req_r.addr;
    end else if (sc_done) begin
      link_flag_r <= 1'b0;
    end
  end

  always_comb begin
    events = '0;
    events[EV_LOAD_DONE] = load_ok;
    events[EV_ADDR_ERR] = issue.valid && state_r == LLU_IDLE && (dec_word | dec_double) && dec_mis && !dec_rsvd;
    events[EV_XLAT_ERR] = state_r == LLU_WAIT && mem_rsp.valid && (mem_rsp.xlat_refill | mem_rsp.xlat_invalid);
    events[EV_RSVD] = issue.valid && state_r == LLU_IDLE && dec_rsvd;
  end

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~stat_clr) | events;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mask_r <= '0;
    end else if (mask_wr) begin
      mask_r <= mask_wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((status_r & ~stat_clr) | events) & mask_r);
    end
  end
endmodule

// *** verification/llu_mem_model.sv ***
`timescale 1ns/100ps
module llu_mem_model
  import llu_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Request, delay and fault knobs
  input wire llu_pkg::llu_mem_req_s req,
  input wire logic [1:0] slow,
  input wire logic [1:0] fault,
  // Response
  output llu_pkg::llu_mem_rsp_s rsp
);
  logic [2:0] wait_r;
  logic [63:0] addr_r;
  // Idle data toggles so a stale lane never passes for a fresh one
  always_ff @(posedge sys_clk) begin
    rsp <= {1'b0, ~rsp.data, 2'h0};
    if (!reset_n) begin
      wait_r <= 3'h0;
      rsp <= '0;
    end else if (req.valid) begin
      wait_r <= slow + 3'h1;
      addr_r <= req.addr; // Served as cached memory
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
      if (wait_r == 3'h1) rsp <= {1'b1, ~addr_r[34:3], addr_r[34:3], fault};
    end
  end
endmodule

// *** verification/llu_sva.sv ***
`timescale 1ns/100ps
module llu_sva
  import llu_pkg::*;
(
  // Clock and issue
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire llu_pkg::llu_issue_s issue,
  input wire logic ll_enable,
  input wire logic busy_r,
  input wire logic sc_done,
  // Results
  input wire llu_pkg::llu_mem_req_s mem_req_r,
  input wire llu_pkg::llu_mem_rsp_s mem_rsp,
  input wire llu_pkg::llu_wb_s wb_r,
  input wire llu_pkg::llu_exc_e exc_r,
  input wire logic link_flag_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire [5:0] op = issue.instr[31:26];
  wire [63:0] ea = issue.base_val + {{48{issue.instr[15]}}, issue.instr[15:0]};
  wire go = issue.valid && !busy_r;
  wire w = go && ll_enable && op == OP_LOAD_LINKED_WORD;
  wire d = go && ll_enable && op == OP_LOAD_LINKED_DOUBLE;
  wire r = go && !ll_enable && op[5:3] == 3'h6 && op[1:0] == 2'h0;
  wire ok = busy_r && mem_rsp.valid && !mem_rsp.xlat_refill && !mem_rsp.xlat_invalid;
  a_word_req: assert property (w && ea[1:0] == 2'h0 |=> mem_req_r.valid && mem_req_r.addr == $past(ea))
    else $error("word req");
  a_dbl_req: assert property (d && ea[2:0] == 3'h0 |=> mem_req_r.valid && mem_req_r.is_double)
    else $error("double req");
  a_word_align: assert property (w && ea[1:0] != 2'h0 |=> exc_r == LLU_EXC_ADDR_ERROR && !mem_req_r.valid)
    else $error("word align");
  a_dbl_align: assert property (d && ea[2:0] != 3'h0 |=> exc_r == LLU_EXC_ADDR_ERROR && !mem_req_r.valid)
    else $error("double align");
  a_rsvd_op: assert property (r |=> exc_r == LLU_EXC_RESERVED_INSTR && !mem_req_r.valid)
    else $error("reserved missed");
  a_no_excl: assert property (mem_req_r.valid |-> mem_req_r.shared_only)
    else $error("exclusive fetch");
  a_load_flag: assert property (ok |=> wb_r.valid && link_flag_r)
    else $error("load flag");
  a_sc_end: assert property (sc_done && !ok |=> !link_flag_r)
    else $error("flag kept");
  c_load: cover property (ok);
  c_sc: cover property (sc_done && link_flag_r);
  c_rsvd: cover property (r);
endmodule

// *** verification/load_linked_unit_test.sv ***
`timescale 1ns/100ps
module load_linked_unit_test;
  import llu_pkg::*;
  logic sys_clk, reset_n, ll_enable, be, sc_done, mask_wr, busy_r, link_flag_r, irq_r, en, b, dbl;
  llu_issue_s issue, is;
  llu_mem_req_s mem_req_r;
  llu_mem_rsp_s mem_rsp;
  llu_wb_s wb_r;
  llu_exc_e exc_r, ex;
  logic [63:0] link_addr_r, ea, md, ed;
  logic [3:0] stat_clr, mask_wr_data, status_r, st, m;
  logic [1:0] slow, f, fr;
  int seed = 88;
  int bad_count, n_tests, flag, i, k;
  load_linked_unit dut (.sys_clk, .reset_n, .issue, .ll_enable, .cpu_big_endian_mode(be), .busy_r, .sc_done,
    .mem_req_r, .mem_rsp, .wb_r, .exc_r, .link_flag_r, .link_addr_r, .stat_clr, .mask_wr_data, .mask_wr,
    .status_r, .irq_r);
  llu_mem_model mem (.sys_clk, .reset_n, .req(mem_req_r), .slow, .fault(f), .rsp(mem_rsp));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    reset_n = 0;
    {issue, ll_enable, be, sc_done, mask_wr, stat_clr, mask_wr_data, slow, f} = '0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1;
    for (i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      dbl = $random(seed);
      en = ($random(seed) & 7) != 0;
      b = $random(seed);
      m = $random(seed);
      fr = ($random(seed) & 7) == 0 ? 2'h2 : (($random(seed) & 7) == 0 ? 2'h1 : 2'h0);
      is = {1'b1, $random(seed), $random(seed), $random(seed)};
      is.instr[31:26] = dbl ? OP_LOAD_LINKED_DOUBLE : OP_LOAD_LINKED_WORD;
      if ($random(seed) & 3) begin
        is.base_val[2:0] = 3'h0;
        is.instr[1:0] = 2'h0;
      end
      ea = is.base_val + {{48{is.instr[15]}}, is.instr[15:0]};
      md = {~ea[34:3], ea[34:3]};
      ed = dbl ? md : 64'(signed'(ea[2] ^ b ? md[63:32] : md[31:0]));
      ex = !en ? LLU_EXC_RESERVED_INSTR : (ea[1:0] != 2'h0 || dbl && ea[2]) ? LLU_EXC_ADDR_ERROR :
        fr[1] ? LLU_EXC_XLAT_REFILL : fr[0] ? LLU_EXC_XLAT_INVALID : LLU_EXC_NONE;
      st = 4'h1 << (ex == LLU_EXC_NONE ? 0 : ex == LLU_EXC_ADDR_ERROR ? 1 : ex == LLU_EXC_RESERVED_INSTR ? 3 : 2);
      issue <= is;
      ll_enable <= en;
      be <= b;
      f <= fr;
      slow <= $random(seed);
      mask_wr <= 1;
      mask_wr_data <= m;
      @(posedge sys_clk);
      issue.valid <= 0;
      mask_wr <= 0;
      // Issue-time exceptions last one cycle: look after this edge has settled
      #1;
      for (k = 0; k < 20 && !wb_r.valid && exc_r === LLU_EXC_NONE; k++) @(posedge sys_clk) #1;
      chk(exc_r, ex);
      chk(wb_r.valid, ex == LLU_EXC_NONE);
      if (ex == LLU_EXC_NONE) begin
        chk(wb_r.data, ed);
        chk(wb_r.target_reg_field, is.instr[20:16]);
        flag = 1;
      end
      repeat (2) @(posedge sys_clk) #1;
      chk(link_flag_r, flag);
      if (ex == LLU_EXC_NONE) chk(link_addr_r, ea);
      chk(status_r, st);
      chk(irq_r, |(st & m));
      @(posedge sys_clk);
      stat_clr <= 4'hF;
      sc_done <= i % 3 == 0;
      if (i % 3 == 0) flag = 0;
      @(posedge sys_clk);
      stat_clr <= 4'h0;
      sc_done <= 0;
      @(posedge sys_clk) #1;
      chk(status_r, 0);
      chk(link_flag_r, flag);
    end
    tally_and_finish;
  end
endmodule
bind load_linked_unit llu_sva chk (.sys_clk, .reset_n, .issue, .ll_enable, .busy_r, .sc_done, .mem_req_r,
  .mem_rsp, .wb_r, .exc_r, .link_flag_r);
